/* common/sfh_regs.vh */
// Constants for the serial flash hold, protect and status block.
// Assumes inclusion by bare name from the block's design file.
// Contract
// - Pause honoured only while select is low
// - Pause entry waits for serial clock low
// - Pause exit waits for serial clock low
// - Paused: output floated, clock and data ignored
// - Pause keeps the bit position intact
// - Select high while paused abandons transaction
// - Guard pin low, lock set: refuse status write
// - Guard pin high: status write accepted right after unlock
// - Lock-down freezes lock and protection bits
// - Bit 0 busy flag, read-only, resets 0
// - Bit 1 write latch; cleared rejects program and erase
// - Latch clears on disable, non-auto completions, auto completion at top address
// - Protection bits 2,3 writable, reset to 1
// - Protection level selects guarded address range
// - Chip erase only with protection level 0
// - Bits 4 and 5 read as 0
// - Bit 6 shows auto-increment mode, resets 0
// - Lock bit 7 writable, resets to 0
// - Sample on clock rise, shift on fall
// - Status read repeats until select rises
`ifndef SFH_REGS_VH
`define SFH_REGS_VH

// Instruction opcodes
`define SFH_OP_WR_ENABLE_CMD  8'h06
`define SFH_OP_WR_DISABLE_CMD 8'h04
`define SFH_OP_STAT_READ_CMD  8'h05
`define SFH_OP_UNLOCK_CMD     8'h50
`define SFH_OP_STAT_WRITE_CMD 8'h01
`define SFH_OP_PROG       8'h02
`define SFH_OP_AUTO       8'hAF
`define SFH_OP_SECT       8'h20
`define SFH_OP_BLK        8'h52
`define SFH_OP_CHIP       8'h60

// Instruction lengths in bytes
`define SFH_LEN_CMD       3'h1
`define SFH_LEN_STAT      3'h2
`define SFH_LEN_ERASE     3'h4
`define SFH_LEN_PROG      3'h5

// Status field positions
`define SFH_ST_BUSY       0
`define SFH_ST_WR_LATCH   1
`define SFH_ST_BP_LO      2
`define SFH_ST_BP_HI      3
`define SFH_ST_AUTO       6
`define SFH_ST_LOCK       7

// Reset values
`define SFH_BP_RST        2'h3
`define SFH_LOCK_RST      1'h0

// Array operation kinds
`define SFH_KIND_PROG     2'h0
`define SFH_KIND_SECT     2'h1
`define SFH_KIND_BLK      2'h2
`define SFH_KIND_CHIP     2'h3

// Address map
`define SFH_ADDR_TOP      18'h3FFFF
`define SFH_PROT_QUARTER  18'h30000
`define SFH_PROT_HALF     18'h20000

`endif

/* src/sfh_ctrl.v */
// Hold, write protection and status register control of a serial flash.
// Assumes an SPI master in mode 0 or 3 and an array engine on clk that
// answers every op_start_o with one op_done_i pulse.
`timescale 1ns/100ps
`default_nettype none
`include "sfh_regs.vh"

module sfh_ctrl (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// Serial pins
	input  wire        sck_i,
	input  wire        cs_n_i,
	input  wire        si_i,
	input  wire        hold_n_i,
	input  wire        wp_n_i,
	output wire        so_o,
	output wire        so_oe_n_o,
	// Array engine
	output wire        op_start_o,
	output wire [1:0]  op_kind_o,
	output wire [17:0] op_addr_o,
	output wire [7:0]  op_data_o,
	input  wire        op_done_i,
	// Observation
	output wire [7:0]  status_o,
	output wire        paused_o
);

	// Guarded range test for an address at a protection level
	function prot_hit;
		input [17:0] addr;
		input [1:0]  lvl;
		begin
			case (lvl)
				2'h0: prot_hit = 1'b0;
				2'h1: prot_hit = (addr >= `SFH_PROT_QUARTER);
				2'h2: prot_hit = (addr >= `SFH_PROT_HALF);
				2'h3: prot_hit = 1'b1;
				default: prot_hit = 1'b1;
			endcase
		end
	endfunction

	// Pin synchronisers: order wp, hold, si, cs, sck
	reg  [4:0]  meta_r;
	reg  [4:0]  sync_r;
	wire        sck_s;
	wire        cs_s;
	wire        si_s;
	wire        hold_s;
	wire        wp_s;

	// Edge history
	reg         sck_d_r;
	reg         cs_d_r;

	// Pause state
	reg         paused_r;

	// Serial shifter
	reg  [6:0]  sh_r;
	reg  [2:0]  bit_cnt_r;
	reg  [2:0]  byte_cnt_r;
	reg  [7:0]  opcode_r;
	reg  [7:0]  byte1_r;
	reg  [7:0]  byte2_r;
	reg  [7:0]  byte3_r;
	reg  [7:0]  byte4_r;
	reg         stat_rd_act_r;
	reg         so_r;
	reg         so_oe_n_r;

	// Status fields
	reg         busy_r;
	reg         wr_latch_r;
	reg  [1:0]  bp_r;
	reg         auto_r;
	reg         lock_r;
	reg         unlock_armed_r;
	reg  [17:0] auto_addr_r;

	// Array request
	reg         op_start_r;
	reg  [1:0]  op_kind_r;
	reg  [17:0] op_addr_r;
	reg  [7:0]  op_data_r;
	reg         op_auto_r;

	// Decoded terms
	wire        sck_rise;
	wire        sck_fall;
	wire        cs_rise;
	wire [7:0]  byte_in;
	wire [17:0] cmd_addr;
	wire [17:0] auto_next;
	wire [7:0]  status;
	wire        commit;
	wire        lockdown;
	wire        do_wr_enable;
	wire        do_wr_disable;
	wire        do_unlock;
	wire        do_stat_write;
	wire        do_prog;
	wire        do_auto1;
	wire        do_auton;
	wire        do_sect;
	wire        do_blk;
	wire        do_chip;
	wire        launch;
	wire        op_top;

	assign sck_s  = sync_r[0];
	assign cs_s   = sync_r[1];
	assign si_s   = sync_r[2];
	assign hold_s = sync_r[3];
	assign wp_s   = sync_r[4];

	// Two-stage synchroniser, idle pin levels at reset
	always @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= 5'h1A;
			sync_r <= 5'h1A;
		end else begin
			meta_r <= {wp_n_i, hold_n_i, si_i, cs_n_i, sck_i};
			sync_r <= meta_r;
		end
	end

	// Edge history of clock and select
	always @(posedge clk) begin
		if (sys_rst) begin
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r  <= cs_s;
		end
	end

	// Clock edges count only while selected and not paused
	assign sck_rise = sck_s & ~sck_d_r & ~cs_s & ~paused_r;
	assign sck_fall = ~sck_s & sck_d_r & ~cs_s & ~paused_r;
	assign cs_rise  = cs_s & ~cs_d_r;

	// Pause follows hold only while clock is low and select low
	always @(posedge clk) begin
		if (sys_rst) begin
			paused_r <= 1'b0;
		end else if (cs_s) begin
			paused_r <= 1'b0;
		end else if (!sck_s) begin
			paused_r <= ~hold_s;
		end
	end

	// Assembled byte and addresses
	assign byte_in   = {sh_r, si_s};
	assign cmd_addr  = {byte1_r[1:0], byte2_r, byte3_r};
	assign auto_next = auto_addr_r + 18'h00001;

	// Input shifter; pause freezes counters rather than clearing them
	always @(posedge clk) begin
		if (sys_rst || cs_s) begin
			sh_r       <= 7'h00;
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 3'h0;
			stat_rd_act_r <= 1'b0;
		end else if (sck_rise) begin
			sh_r      <= byte_in[6:0];
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				if (byte_cnt_r != 3'h7)
					byte_cnt_r <= byte_cnt_r + 3'h1;
				if (byte_cnt_r == 3'h0 && byte_in == `SFH_OP_STAT_READ_CMD)
					stat_rd_act_r <= 1'b1;
			end
		end
	end

	// Byte capture by position in the instruction
	always @(posedge clk) begin
		if (sys_rst) begin
			opcode_r <= 8'h00;
			byte1_r  <= 8'h00;
			byte2_r  <= 8'h00;
			byte3_r  <= 8'h00;
			byte4_r  <= 8'h00;
		end else if (sck_rise && bit_cnt_r == 3'h7) begin
			case (byte_cnt_r)
				3'h0: opcode_r <= byte_in;
				3'h1: byte1_r <= byte_in;
				3'h2: byte2_r <= byte_in;
				3'h3: byte3_r <= byte_in;
				3'h4: byte4_r <= byte_in;
				default: byte4_r <= byte4_r;
			endcase
		end
	end

	// Status bits shifted out on falling clock, repeating each byte
	always @(posedge clk) begin
		if (sys_rst) begin
			so_r <= 1'b0;
		end else if (sck_fall && stat_rd_act_r) begin
			so_r <= status[~bit_cnt_r];
		end
	end

	// Output enable, floated while paused or deselected
	always @(posedge clk) begin
		if (sys_rst) begin
			so_oe_n_r <= 1'b1;
		end else begin
			so_oe_n_r <= ~(stat_rd_act_r & ~cs_s & ~paused_r);
		end
	end

	// Instructions act on select rising after whole bytes; a pause abandons
	assign commit   = cs_rise & ~paused_r & (bit_cnt_r == 3'h0) & ~busy_r;
	assign lockdown = ~wp_s & lock_r;

	// Latch and status instructions
	assign do_wr_enable  = commit & (opcode_r == `SFH_OP_WR_ENABLE_CMD) & (byte_cnt_r == `SFH_LEN_CMD);
	assign do_wr_disable = commit & (opcode_r == `SFH_OP_WR_DISABLE_CMD) & (byte_cnt_r == `SFH_LEN_CMD);
	assign do_unlock     = commit & (opcode_r == `SFH_OP_UNLOCK_CMD) & (byte_cnt_r == `SFH_LEN_CMD);
	assign do_stat_write = commit & (opcode_r == `SFH_OP_STAT_WRITE_CMD) & (byte_cnt_r == `SFH_LEN_STAT)
	                     & unlock_armed_r & ~lockdown;

	// Write instructions need the latch and an unguarded target
	assign do_prog  = commit & (opcode_r == `SFH_OP_PROG) & (byte_cnt_r == `SFH_LEN_PROG)
	                & wr_latch_r & ~auto_r & ~prot_hit(cmd_addr, bp_r);
	assign do_auto1 = commit & (opcode_r == `SFH_OP_AUTO) & (byte_cnt_r == `SFH_LEN_PROG)
	                & wr_latch_r & ~auto_r & ~prot_hit(cmd_addr, bp_r);
	assign do_auton = commit & (opcode_r == `SFH_OP_AUTO) & (byte_cnt_r == `SFH_LEN_STAT)
	                & wr_latch_r & auto_r & ~prot_hit(auto_next, bp_r);
	assign do_sect  = commit & (opcode_r == `SFH_OP_SECT) & (byte_cnt_r == `SFH_LEN_ERASE)
	                & wr_latch_r & ~auto_r & ~prot_hit(cmd_addr, bp_r);
	assign do_blk   = commit & (opcode_r == `SFH_OP_BLK) & (byte_cnt_r == `SFH_LEN_ERASE)
	                & wr_latch_r & ~auto_r & ~prot_hit(cmd_addr, bp_r);
	assign do_chip  = commit & (opcode_r == `SFH_OP_CHIP) & (byte_cnt_r == `SFH_LEN_CMD)
	                & wr_latch_r & ~auto_r & (bp_r == 2'h0);

	assign launch = do_prog | do_auto1 | do_auton | do_sect | do_blk | do_chip;
	assign op_top = (op_addr_r == `SFH_ADDR_TOP);

	// Array request, one pulse per accepted write
	always @(posedge clk) begin
		if (sys_rst) begin
			op_start_r <= 1'b0;
			op_kind_r  <= `SFH_KIND_PROG;
			op_addr_r  <= 18'h00000;
			op_data_r  <= 8'h00;
			op_auto_r  <= 1'b0;
		end else begin
			op_start_r <= launch;
			if (launch) begin
				op_auto_r <= do_auto1 | do_auton;
				op_data_r <= do_auton ? byte1_r : byte4_r;
				op_addr_r <= do_auton ? auto_next : cmd_addr;
				if (do_sect)
					op_kind_r <= `SFH_KIND_SECT;
				else if (do_blk)
					op_kind_r <= `SFH_KIND_BLK;
				else if (do_chip)
					op_kind_r <= `SFH_KIND_CHIP;
				else
					op_kind_r <= `SFH_KIND_PROG;
			end
		end
	end

	// Busy flag from launch to completion
	always @(posedge clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
		end else if (launch) begin
			busy_r <= 1'b1;
		end else if (op_done_i) begin
			busy_r <= 1'b0;
		end
	end

	// Write enable latch
	always @(posedge clk) begin
		if (sys_rst) begin
			wr_latch_r <= 1'b0;
		end else if (do_wr_enable) begin
			wr_latch_r <= 1'b1;
		end else if (do_wr_disable) begin
			wr_latch_r <= 1'b0;
		end else if (op_done_i && busy_r && (!op_auto_r || op_top)) begin
			wr_latch_r <= 1'b0;
		end
	end

	// Auto-increment mode and its running address
	always @(posedge clk) begin
		if (sys_rst) begin
			auto_r      <= 1'b0;
			auto_addr_r <= 18'h00000;
		end else begin
			if (do_auto1 || do_auton)
				auto_addr_r <= do_auton ? auto_next : cmd_addr;
			if (do_auto1)
				auto_r <= 1'b1;
			else if (do_wr_disable)
				auto_r <= 1'b0;
			else if (op_done_i && busy_r && op_auto_r && op_top)
				auto_r <= 1'b0;
		end
	end

	// Unlock arms only the very next instruction
	always @(posedge clk) begin
		if (sys_rst) begin
			unlock_armed_r <= 1'b0;
		end else if (cs_rise && !paused_r && byte_cnt_r != 3'h0) begin
			unlock_armed_r <= do_unlock;
		end
	end

	// Protection level and lock, written only when permitted
	always @(posedge clk) begin
		if (sys_rst) begin
			bp_r   <= `SFH_BP_RST;
			lock_r <= `SFH_LOCK_RST;
		end else if (do_stat_write) begin
			bp_r   <= byte1_r[`SFH_ST_BP_HI:`SFH_ST_BP_LO];
			lock_r <= byte1_r[`SFH_ST_LOCK];
		end
	end

	// Status byte, reserved bits fixed at zero
	assign status = {lock_r, auto_r, 2'b00, bp_r, wr_latch_r, busy_r};

	// Outputs
	assign so_o       = so_r;
	assign so_oe_n_o  = so_oe_n_r;
	assign op_start_o = op_start_r;
	assign op_kind_o  = op_kind_r;
	assign op_addr_o  = op_addr_r;
	assign op_data_o  = op_data_r;
	assign status_o   = status;
	assign paused_o   = paused_r;

endmodule // sfh_ctrl
`default_nettype wire

/* tb/sfh_ctrl_asserts.sv */
// Port checker for the hold, protect and status block.
// Assumes pins stay stable at least 4 clk around each change.
`timescale 1ns/100ps
`default_nettype none

module sfh_ctrl_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Serial pins
	input wire logic        sck_i,
	input wire logic        cs_n_i,
	input wire logic        si_i,
	input wire logic        hold_n_i,
	input wire logic        wp_n_i,
	input wire logic        so_o,
	input wire logic        so_oe_n_o,
	// Array engine
	input wire logic        op_start_o,
	input wire logic [1:0]  op_kind_o,
	input wire logic [17:0] op_addr_o,
	input wire logic [7:0]  op_data_o,
	input wire logic        op_done_i,
	// Observation
	input wire logic [7:0]  status_o,
	input wire logic        paused_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [1:0] bp_r;

	// Protection level seen before a launch
	always @(posedge clk) begin
		bp_r <= status_o[3:2];
	end

	// Pause handling
	pause_float_a: assert property (paused_o && $past(paused_o) |-> so_oe_n_o) else $error("pause drives output");
	pause_entry_a: assert property ($rose(paused_o) |-> !$past(hold_n_i, 3) && !$past(cs_n_i, 3) && !$past(sck_i, 3))
		else $error("bad pause entry");
	pause_exit_a: assert property ($fell(paused_o) |-> ($past(hold_n_i, 3) && !$past(sck_i, 3)) || $past(cs_n_i, 3))
		else $error("bad pause exit");
	cs_abort_a: assert property (cs_n_i [*4] |-> !paused_o) else $error("pause kept while deselected");
	// Status bits and launches
	reserved_zero_a: assert property (status_o[5:4] == 2'h0) else $error("reserved bits set");
	launch_busy_a: assert property (op_start_o |-> status_o[0] && !$past(status_o[0])) else $error("busy wrong");
	launch_wel_a: assert property (op_start_o |-> $past(status_o[1])) else $error("launch without latch");
	chip_erase_a: assert property (op_start_o && op_kind_o == 2'h3 |-> bp_r == 2'h0) else $error("chip erase guarded");
	protect_range_a: assert property (op_start_o && op_kind_o != 2'h3 |-> bp_r != 2'h3 &&
		!(bp_r == 2'h1 && op_addr_o >= 18'h30000) && !(bp_r == 2'h2 && op_addr_o >= 18'h20000)) else $error("guarded");
	done_clear_a: assert property (op_done_i && status_o[0] && !status_o[6] |=> status_o[1:0] == 2'h0)
		else $error("busy or latch kept");
	lock_down_a: assert property (!wp_n_i [*4] ##0 status_o[7] |=> $stable(status_o[7]) && $stable(status_o[3:2]))
		else $error("locked bits changed");
endmodule // sfh_ctrl_chk

bind sfh_ctrl sfh_ctrl_chk u_sfh_ctrl_chk (.clk, .sys_rst, .sck_i, .cs_n_i, .si_i, .hold_n_i, .wp_n_i, .so_o,
	.so_oe_n_o, .op_start_o, .op_kind_o, .op_addr_o, .op_data_o, .op_done_i, .status_o, .paused_o);

`default_nettype wire

/* tb/sfh_host.sv */
// SPI host model: clock, select, data and pause pins.
// Assumes a 40 MHz clk; pins move at its fall, sck half period 4 clk.
`timescale 1ns/100ps
`default_nettype none

module sfh_host (
	// Bench clock
	input  wire logic clk,
	// Serial pins
	input  wire logic so,
	output var logic  sck,
	output var logic  cs_n,
	output var logic  si,
	output var logic  hold_n
);
	// Idle: deselected, clock parked low
	initial begin
		sck = 1'h0;
		cs_n = 1'h1;
		si = 1'h0;
		hold_n = 1'h1;
	end

	// Half a serial clock period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	// Frame of n bytes right aligned in d; pause at bit hb, abort in pause on ab
	task automatic frame(input logic [39:0] d, input int n, input int hb, input bit ab, output logic [7:0] rd);
		int i;
		cs_n = 1'h0;
		half();
		for (i = 0; i < 8 * n; i++) begin
			if (i == hb) begin
				hold_n = 1'h0; // Pause with select and clock low
				half();
				repeat (2) begin
					sck = ~sck; // Noise to be ignored
					si = ~si;
					half();
				end
				if (ab) begin
					cs_n = 1'h1;
					half();
					hold_n = 1'h1;
					half();
					return;
				end
				hold_n = 1'h1; // Resume with select low
				half();
			end
			si = d[8 * n - 1 - i]; // MSB first, taken at rise
			half();
			sck = 1'h1;
			rd = {rd[6:0], so};
			half();
			sck = 1'h0;
		end
		half();
		cs_n = 1'h1;
		si = ~si; // Released line loses its value
		half();
		half();
	endtask
endmodule // sfh_host

`default_nettype wire

/* tb/sfh_ctrl_tb.sv */
// Self-checking bench for the hold, protect and status block.
// Assumes sfh_host as serial partner; the bench plays the array engine.
`timescale 1ns/100ps
`default_nettype none

module sfh_ctrl_tb;
	logic        clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic        wp_n = 1'h1;
	logic        op_done = 1'h0;
	wire         sck, cs_n, si, hold_n, so, so_oe_n, op_start, paused;
	wire  [1:0]  op_kind;
	wire  [17:0] op_addr;
	wire  [7:0]  op_data, status;
	logic [7:0]  rd;
	logic [63:0] r;
	int          n_errors = 0;
	int          check_count = 0;
	int          n_launch = 0;
	int          dly = 0;
	int          c;
	int          i;
	// Rows: frame bytes, byte count, guard pin, status after, launch and kind
	logic [63:0] rows [0:27] = '{
		64'h0000000006_1_1_0E_00, 64'h0000000004_1_1_0C_00, 64'h0000000006_1_1_0E_00,
		64'h0200001055_5_1_0E_00, 64'h0000000060_1_1_0E_00, 64'h0000000184_2_1_0E_00,
		64'h0000000050_1_1_0E_00, 64'h0000000184_2_1_86_00, 64'h02030000AA_5_1_86_00,
		64'h0202FFFFAA_5_1_84_10, 64'h0000000050_1_0_84_00, 64'h0000000100_2_0_84_00,
		64'h0000000050_1_1_84_00, 64'h0000000100_2_1_00_00, 64'h0000000006_1_1_02_00,
		64'h0000000060_1_1_00_13, 64'h0000000006_1_1_02_00, 64'h0020030000_4_1_00_11,
		64'h0000000006_1_1_02_00, 64'h0052030000_4_1_00_12, 64'h0200000011_5_1_00_00,
		64'h0000000050_1_0_00_00, 64'h0000000188_2_0_88_00, 64'h0000000050_1_1_88_00,
		64'h0000000100_2_1_00_00, 64'h0000000006_1_1_02_00, 64'hAF03FFFE11_5_1_42_10,
		64'h000000AF22_2_1_00_10};

	sfh_ctrl u_sfh_ctrl (.clk, .sys_rst, .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n),
		.so_o(so), .so_oe_n_o(so_oe_n), .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr),
		.op_data_o(op_data), .op_done_i(op_done), .status_o(status), .paused_o(paused));
	sfh_host u_sfh_host (.clk, .so(so_oe_n ? 1'hZ : so), .sck, .cs_n, .si, .hold_n);

	// Clock
	always #12.5 clk = ~clk;

	// Array engine: ends each launch 20 clk later
	always @(negedge clk) begin
		op_done <= (dly == 1);
		if (op_start)
			n_launch++;
		dly <= op_start ? 20 : (dly > 0 ? dly - 1 : 0);
	end

	// Compare and count
	task automatic chk(input logic [17:0] a, input logic [17:0] e);
		check_count++;
		if (a !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, a, e);
		end
	endtask

	// Status read of three bytes, last repeat compared
	task automatic stat_read(input logic [7:0] e);
		u_sfh_host.frame(40'h050000, 3, -1, 1'b0, rd);
		chk(rd, e);
		chk(status, e);
	endtask

	// Verdict and end of run
	task automatic stop_test();
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'h0;
		chk(status, 8'h0C);
		chk(so_oe_n, 1'h1);
		repeat (4) @(negedge clk);
		for (i = 0; i < 28; i++) begin
			r = rows[i];
			wp_n = r[16];
			c = n_launch;
			u_sfh_host.frame(r[63:24], int'(r[23:20]), -1, 1'b0, rd);
			if (r[63:24] == 40'h50)
				chk(status, r[15:8]); // Any frame here would disarm the unlock
			else
				stat_read(r[15:8]);
			chk(18'(n_launch - c), r[4]);
			if (r[4]) begin
				chk(op_kind, r[1:0]);
				if (r[23:20] > 4'h3)
					chk(op_addr, r[23:20] == 4'h5 ? r[49:32] : r[41:24]);
				if (r[1:0] == 2'h0)
					chk(op_data, r[31:24]);
			end
		end
		// Abort in pause, then pauses inside a write enable and a read
		u_sfh_host.frame(40'h0600, 2, 8, 1'b1, rd);
		chk(paused, 1'h0);
		stat_read(8'h00);
		u_sfh_host.frame(40'h06, 1, 5, 1'b0, rd);
		stat_read(8'h02);
		u_sfh_host.frame(40'h0500, 2, 12, 1'b0, rd);
		chk(rd, 8'h02);
		// Second reset mid-run
		sys_rst = 1'h1;
		repeat (2) @(negedge clk);
		sys_rst = 1'h0;
		chk(status, 8'h0C);
		stop_test();
	end

	// Watchdog
	initial begin
		#1000000;
		n_errors++;
		stop_test();
	end
endmodule // sfh_ctrl_tb

`default_nettype wire
